/* File: core/cmp_flags_if.sv */
// Purpose: Carries the compare operands to the flag unit and its flags back.
// Assumes: Purely combinational exchange within one clock.
// Notes: The unit modport is the flag calculator, the user modport the sequencer.
`timescale 1ns/10ps
interface cmp_flags_if;
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
    logic halfCarry;

    modport unit (
        input minuend,
        input subtrahend,
        output zero,
        output negative,
        output overflow,
        output carry,
        output halfCarry
    );

    modport user (
        output minuend,
        output subtrahend,
        input zero,
        input negative,
        input overflow,
        input carry,
        input halfCarry
    );
endinterface : cmp_flags_if

/* File: core/cmp_skip_pkg.sv */
// Purpose: Shared constants and types for the compare, skip and branch execution block.
// Assumes: 16-bit word program counter, 8-bit data, 8-bit flag register.
// Notes: Flag bit positions follow the usual processor flag register layout.
package cmp_skip_pkg;

    // Data path and program counter widths.
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int OFFSET_W = 7;

    // Flag register bit positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;

    // Program counter steps in words.
    localparam logic [15:0] PC_STEP_NEXT = 16'h0001;
    localparam logic [15:0] PC_STEP_SKIP_ONE = 16'h0002;
    localparam logic [15:0] PC_STEP_SKIP_TWO = 16'h0003;

    // Cycle counts for each outcome.
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Reset values of the result registers.
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // Instructions handled by the block.
    typedef enum logic [2:0] {
        OP_CMP_IMM,
        OP_SKIP_REG_BIT_CLEAR,
        OP_SKIP_REG_BIT_SET,
        OP_SKIP_IO_BIT_CLEAR,
        OP_SKIP_IO_BIT_SET,
        OP_BRANCH_FLAG_SET,
        OP_BRANCH_FLAG_CLEAR
    } op_t;

    // Sequencer states.
    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } state_t;

endpackage : cmp_skip_pkg

/* File: core/compare_flag_unit.sv */
// Purpose: Computes the flags of an 8-bit subtraction whose result is discarded.
// Assumes: Operands are stable within the cycle; no state is kept.
// Notes: Borrow-style carry and half carry as for a subtract.
`timescale 1ns/10ps
module compare_flag_unit (
    cmp_flags_if.unit port
);

    logic [7:0] diff;

    // Difference and flag terms; the difference goes nowhere but the flags.
    always_comb
    begin
        diff = port.minuend - port.subtrahend;
        port.zero = (diff == 8'h00);
        port.negative = diff[7];
        port.overflow = (port.minuend[7] & ~port.subtrahend[7] & ~diff[7])
            | (~port.minuend[7] & port.subtrahend[7] & diff[7]);
        port.carry = (~port.minuend[7] & port.subtrahend[7])
            | (port.subtrahend[7] & diff[7]) | (diff[7] & ~port.minuend[7]);
        port.halfCarry = (~port.minuend[3] & port.subtrahend[3])
            | (port.subtrahend[3] & diff[3]) | (diff[3] & ~port.minuend[3]);
    end

endmodule : compare_flag_unit

/* File: core/compare_skip_branch_exec.sv */
// Purpose: Executes compare-with-immediate, bit skips and flag branches.
// Assumes: Operands, program counter and flags come from same-clock core logic.
// Notes: One instruction at a time; inReady shows when the next may issue.
`timescale 1ns/10ps
module compare_skip_branch_exec (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic issueValid,
    input wire cmp_skip_pkg::op_t opcode,
    input wire logic [7:0] dstValue,
    input wire logic [7:0] immValue,
    input wire logic [7:0] srcValue,
    input wire logic [2:0] bitSel,
    input wire logic [6:0] branchOffset,
    input wire logic [15:0] pcIn,
    input wire logic [7:0] flagsIn,
    input wire logic nextTwoWord,
    output logic inReady,
    output logic outValid,
    output logic [15:0] pcOut,
    output logic [7:0] flagsOut,
    output logic flagsWriteEn,
    output logic condTaken
);

    typedef struct packed {
        cmp_skip_pkg::state_t state;
        logic [1:0] waitCnt;
        logic done;
        logic [15:0] pc;
        logic [7:0] flags;
        logic flagsWe;
        logic taken;
    } exec_state_t;

    exec_state_t cur_ff;
    exec_state_t nxt_cur;
    logic cond;
    logic [1:0] cycles;
    logic accept;
    logic [15:0] branchTarget;

    cmp_flags_if cmpBus ();

    compare_flag_unit u_flags (
        .port(cmpBus.unit)
    );

    // Adds a word step to a program counter value, wrapping at the top.
    function automatic logic [15:0] pcAdd(input logic [15:0] pc, input logic [15:0] delta);
        pcAdd = pc + delta;
    endfunction : pcAdd

    // Compare operands always follow the current request.
    assign cmpBus.minuend = dstValue;
    assign cmpBus.subtrahend = immValue;

    // Request handshake and the branch destination.
    assign inReady = (cur_ff.state == cmp_skip_pkg::ST_IDLE);
    assign accept = issueValid && inReady;
    assign branchTarget = pcAdd(pcIn, pcAdd({{9{branchOffset[6]}}, branchOffset},
        cmp_skip_pkg::PC_STEP_NEXT));

    // Condition under test for the current request.
    always_comb
    begin
        case (opcode)
            cmp_skip_pkg::OP_SKIP_REG_BIT_CLEAR: cond = ~srcValue[bitSel];
            cmp_skip_pkg::OP_SKIP_REG_BIT_SET: cond = srcValue[bitSel];
            cmp_skip_pkg::OP_SKIP_IO_BIT_CLEAR: cond = ~srcValue[bitSel];
            cmp_skip_pkg::OP_SKIP_IO_BIT_SET: cond = srcValue[bitSel];
            cmp_skip_pkg::OP_BRANCH_FLAG_SET: cond = flagsIn[bitSel];
            cmp_skip_pkg::OP_BRANCH_FLAG_CLEAR: cond = ~flagsIn[bitSel];
            default: cond = 1'b0;
        endcase
    end

    // Next-state logic: result is fixed on accept, then the cycle count runs out.
    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        cycles = cmp_skip_pkg::CYC_ONE;
        case (cur_ff.state)
            cmp_skip_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    nxt_cur.flags = flagsIn;
                    nxt_cur.flagsWe = 1'b0;
                    nxt_cur.taken = cond;
                    nxt_cur.pc = pcAdd(pcIn, cmp_skip_pkg::PC_STEP_NEXT);
                    case (opcode)
                        cmp_skip_pkg::OP_CMP_IMM:
                        begin
                            nxt_cur.flags[cmp_skip_pkg::FLAG_Z] = cmpBus.zero;
                            nxt_cur.flags[cmp_skip_pkg::FLAG_N] = cmpBus.negative;
                            nxt_cur.flags[cmp_skip_pkg::FLAG_V] = cmpBus.overflow;
                            nxt_cur.flags[cmp_skip_pkg::FLAG_C] = cmpBus.carry;
                            nxt_cur.flags[cmp_skip_pkg::FLAG_H] = cmpBus.halfCarry;
                            nxt_cur.flagsWe = 1'b1;
                        end
                        cmp_skip_pkg::OP_BRANCH_FLAG_SET, cmp_skip_pkg::OP_BRANCH_FLAG_CLEAR:
                        begin
                            if (cond)
                            begin
                                nxt_cur.pc = branchTarget;
                                cycles = cmp_skip_pkg::CYC_TWO;
                            end
                        end
                        default:
                        begin
                            if (cond)
                            begin
                                nxt_cur.pc = pcAdd(pcIn, nextTwoWord ?
                                    cmp_skip_pkg::PC_STEP_SKIP_TWO :
                                    cmp_skip_pkg::PC_STEP_SKIP_ONE);
                                cycles = nextTwoWord ? cmp_skip_pkg::CYC_THREE
                                    : cmp_skip_pkg::CYC_TWO;
                            end
                        end
                    endcase
                    if (cycles == cmp_skip_pkg::CYC_ONE)
                    begin
                        nxt_cur.done = 1'b1;
                    end
                    else
                    begin
                        nxt_cur.state = cmp_skip_pkg::ST_WAIT;
                        nxt_cur.waitCnt = cycles - cmp_skip_pkg::CYC_TWO;
                    end
                end
            end
            cmp_skip_pkg::ST_WAIT:
            begin
                if (cur_ff.waitCnt == 2'h0)
                begin
                    nxt_cur.done = 1'b1;
                    nxt_cur.state = cmp_skip_pkg::ST_IDLE;
                end
                else
                begin
                    nxt_cur.waitCnt = cur_ff.waitCnt - 2'h1;
                end
            end
            default:
            begin
                nxt_cur.state = cmp_skip_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_ff.state <= cmp_skip_pkg::ST_IDLE;
            cur_ff.waitCnt <= 2'h0;
            cur_ff.done <= 1'b0;
            cur_ff.pc <= cmp_skip_pkg::PC_RESET;
            cur_ff.flags <= cmp_skip_pkg::FLAGS_RESET;
            cur_ff.flagsWe <= 1'b0;
            cur_ff.taken <= 1'b0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Results; flags are written back only for a compare.
    assign outValid = cur_ff.done;
    assign pcOut = cur_ff.pc;
    assign flagsOut = cur_ff.flags;
    assign flagsWriteEn = cur_ff.done && cur_ff.flagsWe;
    assign condTaken = cur_ff.taken;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Compare finishes next cycle with zero and carry from the subtraction.
    property p_cmp_result;
        accept && opcode == cmp_skip_pkg::OP_CMP_IMM |=> outValid && flagsWriteEn
            && flagsOut[cmp_skip_pkg::FLAG_Z] == ($past(dstValue) == $past(immValue))
            && flagsOut[cmp_skip_pkg::FLAG_C] == ($past(dstValue) < $past(immValue));
    endproperty
    a_cmp_result: assert property (p_cmp_result) else $error("compare result wrong");

    // A register-bit-clear skip over one word lands two words on.
    property p_skip_reg_clear;
        accept && opcode == cmp_skip_pkg::OP_SKIP_REG_BIT_CLEAR && cond && !nextTwoWord
            |=> !outValid ##1 outValid && pcOut == $past(pcIn, 2) + 16'h0002;
    endproperty
    a_skip_reg_clear: assert property (p_skip_reg_clear) else $error("skip clear bad");

    // A register-bit-set skip over two words lands three words on.
    property p_skip_reg_set;
        accept && opcode == cmp_skip_pkg::OP_SKIP_REG_BIT_SET && cond && nextTwoWord
            |=> !outValid [*2] ##1 outValid && pcOut == $past(pcIn, 3) + 16'h0003;
    endproperty
    a_skip_reg_set: assert property (p_skip_reg_set) else $error("skip set bad");

    // Io skips keep the flags seen at the accept, even if the inputs move while busy.
    property p_skip_io_flags;
        accept && (opcode == cmp_skip_pkg::OP_SKIP_IO_BIT_CLEAR
            || opcode == cmp_skip_pkg::OP_SKIP_IO_BIT_SET)
            |=> flagsOut == $past(flagsIn) && !flagsWriteEn
            ##[0:2] outValid && !flagsWriteEn;
    endproperty
    a_skip_io_flags: assert property (p_skip_io_flags) else $error("skip flags bad");

    // An io-bit-set skip whose bit is clear finishes in one cycle.
    property p_skip_io_set_false;
        accept && opcode == cmp_skip_pkg::OP_SKIP_IO_BIT_SET && !srcValue[bitSel]
            |=> outValid && !condTaken && pcOut == $past(pcIn) + 16'h0001;
    endproperty
    a_skip_io_set_false: assert property (p_skip_io_set_false) else $error("io skip bad");

    // A taken flag-set branch reaches its target in two cycles.
    property p_branch_set;
        accept && opcode == cmp_skip_pkg::OP_BRANCH_FLAG_SET && flagsIn[bitSel]
            |=> !outValid ##1 outValid && pcOut == $past(pcIn, 2)
            + {{9{$past(branchOffset[6], 2)}}, $past(branchOffset, 2)} + 16'h0001;
    endproperty
    a_branch_set: assert property (p_branch_set) else $error("branch set bad");

    // An untaken flag-clear branch falls through in one cycle.
    property p_branch_clear;
        accept && opcode == cmp_skip_pkg::OP_BRANCH_FLAG_CLEAR && flagsIn[bitSel]
            |=> outValid && pcOut == $past(pcIn) + 16'h0001 && !flagsWriteEn;
    endproperty
    a_branch_clear: assert property (p_branch_clear) else $error("branch clear bad");

    // The block is never busy for more than two cycles after an accept.
    property p_ready_returns;
        $fell(inReady) |-> ##[1:2] inReady;
    endproperty
    a_ready_returns: assert property (p_ready_returns) else $error("busy too long");

    c_cmp: cover property (accept && opcode == cmp_skip_pkg::OP_CMP_IMM);
    c_skip_two: cover property (accept && cond && nextTwoWord
        && opcode == cmp_skip_pkg::OP_SKIP_IO_BIT_CLEAR);
    c_branch: cover property (accept && cond && opcode == cmp_skip_pkg::OP_BRANCH_FLAG_CLEAR);
    c_back_to_back: cover property (accept ##1 accept);

endmodule : compare_skip_branch_exec

/* File: testbench/compare_skip_branch_exec_test.sv */
// Purpose: Self-checking bench for the compare, skip and branch execution block.
// Assumes: Inputs change on the falling edge; results are read on the first falling edge that shows outValid high.
// Notes: Expected values are worked out here from the instruction semantics.
`timescale 1ns/10ps
module compare_skip_branch_exec_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic issueValid = 1'b0;
    cmp_skip_pkg::op_t opcode = cmp_skip_pkg::OP_CMP_IMM;
    logic [7:0] dstValue = 8'h00;
    logic [7:0] immValue = 8'h00;
    logic [7:0] srcValue = 8'h00;
    logic [2:0] bitSel = 3'h0;
    logic [6:0] branchOffset = 7'h00;
    logic [15:0] pcIn = 16'h0000;
    logic [7:0] flagsIn = 8'h00;
    logic nextTwoWord = 1'b0;
    logic inReady;
    logic outValid;
    logic [15:0] pcOut;
    logic [7:0] flagsOut;
    logic flagsWriteEn;
    logic condTaken;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    compare_skip_branch_exec compare_skip_branch_exec_inst (
        .clk(clk),
        .arst_n(arst_n),
        .issueValid(issueValid),
        .opcode(opcode),
        .dstValue(dstValue),
        .immValue(immValue),
        .srcValue(srcValue),
        .bitSel(bitSel),
        .branchOffset(branchOffset),
        .pcIn(pcIn),
        .flagsIn(flagsIn),
        .nextTwoWord(nextTwoWord),
        .inReady(inReady),
        .outValid(outValid),
        .pcOut(pcOut),
        .flagsOut(flagsOut),
        .flagsWriteEn(flagsWriteEn),
        .condTaken(condTaken)
    );

    // Clock of 25 ns period.
    always #12.5 clk = ~clk;

    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    // Compares one result value and counts mismatches.
    task chk(input string what, input logic [15:0] expV, input logic [15:0] gotV);
        cmp_count++;
        if (gotV !== expV)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, expV, gotV);
        end
    endtask : chk

    // Flag register expected after subtracting i from d.
    function automatic logic [7:0] cmp_flags(input logic [7:0] d, i, f);
        logic [7:0] r;
        logic [7:0] o;
        r = d - i;
        o = f;
        o[cmp_skip_pkg::FLAG_C] = d < i;
        o[cmp_skip_pkg::FLAG_Z] = r == 8'h00;
        o[cmp_skip_pkg::FLAG_N] = r[7];
        o[cmp_skip_pkg::FLAG_V] = (d[7] != i[7]) && (r[7] != d[7]);
        o[cmp_skip_pkg::FLAG_H] = d[3:0] < i[3:0];
        return o;
    endfunction : cmp_flags

    // Issues one instruction, counts cycles to the result and checks every output.
    task run_op(input cmp_skip_pkg::op_t op, input logic [7:0] d, i, s, input logic [2:0] b,
        input logic [6:0] k, input logic [15:0] pc, input logic [7:0] fl, input logic two,
        input int expCyc, input logic [15:0] expPc, input logic [7:0] expFl, input logic tk);
        int n;
        n = 0;
        opcode = op;
        dstValue = d;
        immValue = i;
        srcValue = s;
        bitSel = b;
        branchOffset = k;
        pcIn = pc;
        flagsIn = fl;
        nextTwoWord = two;
        issueValid = 1'b1;
        chk("inReady", 16'h0001, 16'(inReady));
        do
        begin
            @(negedge clk);
            n++;
            // A one-cycle result leaves the request up so the next call issues back to back.
            if (outValid !== 1'b1)
            begin
                issueValid = 1'b0;
            end
        end while (n < 5 && outValid !== 1'b1);
        chk("cycles", 16'(expCyc), 16'(n));
        chk("pcOut", expPc, pcOut);
        chk("flagsOut", 16'(expFl), 16'(flagsOut));
        chk("flagsWriteEn", 16'(op == cmp_skip_pkg::OP_CMP_IMM), 16'(flagsWriteEn));
        chk("condTaken", 16'(tk), 16'(condTaken));
        chk("inReady", 16'h0001, 16'(inReady));
    endtask : run_op

    // Checks the outputs held during and just after reset.
    task chk_reset;
        chk("rst inReady", 16'h0001, 16'(inReady));
        chk("rst outValid", 16'h0000, 16'(outValid));
        chk("rst pcOut", 16'h0000, pcOut);
        chk("rst flagsOut", 16'h0000, 16'(flagsOut));
        chk("rst flagsWriteEn", 16'h0000, 16'(flagsWriteEn));
        chk("rst condTaken", 16'h0000, 16'(condTaken));
    endtask : chk_reset

    // Compares covering overflow, half borrow, full borrow and equality, back to back.
    task automatic t_compare;
        logic [7:0] d [4] = '{8'h80, 8'h10, 8'h00, 8'h5A};
        logic [7:0] i [4] = '{8'h01, 8'h01, 8'h01, 8'h5A};
        logic [7:0] f;
        for (int c = 0; c < 4; c++)
        begin
            f = c[0] ? 8'hFF : 8'h00;
            run_op(cmp_skip_pkg::OP_CMP_IMM, d[c], i[c], 8'hC3, 3'h0, 7'h00, 16'h0100, f, 1'b1,
                1, 16'h0101, cmp_flags(d[c], i[c], f), 1'b0);
        end
    endtask : t_compare

    // Every skip with the tested bit true and false, one- and two-word followers.
    task automatic t_skips;
        cmp_skip_pkg::op_t ops [4] = '{cmp_skip_pkg::OP_SKIP_REG_BIT_CLEAR,
            cmp_skip_pkg::OP_SKIP_REG_BIT_SET, cmp_skip_pkg::OP_SKIP_IO_BIT_CLEAR,
            cmp_skip_pkg::OP_SKIP_IO_BIT_SET};
        logic [2:0] b;
        logic [7:0] s;
        logic tk;
        for (int o = 0; o < 4; o++)
            for (int v = 0; v < 2; v++)
                for (int t = 0; t < 2; t++)
                begin
                    b = 3'(o * 2 + v);
                    s = v ? (8'h01 << b) : ~(8'h01 << b);
                    tk = o[0] ? v[0] : !v[0];
                    run_op(ops[o], 8'h00, 8'h00, s, b, 7'h00, 16'hFFFE, 8'hA5, t[0],
                        tk ? 2 + t : 1, 16'hFFFE + (tk ? 16'(2 + t) : 16'h0001), 8'hA5,
                        tk);
                end
    endtask : t_skips

    // Both branches with the flag set and clear, extreme offsets, pc wrapping.
    task automatic t_branches;
        cmp_skip_pkg::op_t ops [2] = '{cmp_skip_pkg::OP_BRANCH_FLAG_SET,
            cmp_skip_pkg::OP_BRANCH_FLAG_CLEAR};
        logic [6:0] k [2] = '{7'h3F, 7'h40};
        logic [2:0] b;
        logic [7:0] f;
        logic tk;
        for (int o = 0; o < 2; o++)
            for (int v = 0; v < 2; v++)
                for (int j = 0; j < 2; j++)
                begin
                    b = 3'(o * 4 + v * 2 + j);
                    f = v ? (8'h01 << b) : ~(8'h01 << b);
                    tk = o ? !v[0] : v[0];
                    run_op(ops[o], 8'h00, 8'h00, 8'h00, b, k[j], 16'h0010, f, 1'b1,
                        tk ? 2 : 1, 16'h0011 + (tk ? {{9{k[j][6]}}, k[j]} : 16'h0000), f,
                        tk);
                end
    endtask : t_branches

    // A request held while busy is ignored and not queued behind a three-cycle skip.
    task t_refused;
        opcode = cmp_skip_pkg::OP_SKIP_REG_BIT_SET;
        srcValue = 8'h80;
        bitSel = 3'h7;
        pcIn = 16'h1234;
        nextTwoWord = 1'b1;
        issueValid = 1'b1;
        @(negedge clk);
        opcode = cmp_skip_pkg::OP_CMP_IMM;
        pcIn = 16'h4000;
        chk("busy inReady", 16'h0000, 16'(inReady));
        @(negedge clk);
        chk("busy inReady", 16'h0000, 16'(inReady));
        issueValid = 1'b0;
        @(negedge clk);
        chk("late outValid", 16'h0001, 16'(outValid));
        chk("late pcOut", 16'h1237, pcOut);
        @(negedge clk);
        chk("no queued op", 16'h0000, 16'(outValid));
        chk("held pcOut", 16'h1237, pcOut);
    endtask : t_refused

    // Reset in the middle of a taken branch clears all results.
    task t_mid_reset;
        opcode = cmp_skip_pkg::OP_BRANCH_FLAG_SET;
        flagsIn = 8'h01;
        bitSel = 3'h0;
        issueValid = 1'b1;
        @(negedge clk);
        issueValid = 1'b0;
        arst_n = 1'b0;
        #1;
        chk_reset();
        @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk_reset();
    endtask : t_mid_reset

    // Bench sequence from reset to verdict.
    initial
    begin
        repeat (5) @(negedge clk);
        chk_reset();
        arst_n = 1'b1;
        @(negedge clk);
        chk_reset();
        t_compare();
        t_skips();
        t_branches();
        t_refused();
        t_mid_reset();
        t_compare();
        print_verdict();
    end

    // Prints the verdict and ends the run.
    task print_verdict;
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
endmodule : compare_skip_branch_exec_test
